// *** pkg/fsws_pkg.sv ***
/*
 Shared constants and types of the flash self-write sequencer.
 Assumes a 125 MHz core clock and an 8-bit register view on Wishbone.
*/
package fsws_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI = 8'h0c;
  localparam logic [7:0] OFS_DATA_LO = 8'h10;
  localparam logic [7:0] OFS_DATA_HI = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int WORD_W = 14;
  localparam logic [13:0] BLANK_WORD = 14'h3fff;
  localparam int LATCH_COUNT = 16;
  localparam int LATCH_IDX_W = 4;
  localparam int USER_ID_WORDS = 4;
  localparam logic [14:0] CFG_DEVID_ADDR = 15'h0006;
  localparam int ARRAY_WORDS = 1024;
  localparam int CLK_MHZ = 125;
  localparam int FLASH_OP_TIME_US = 2000;
  localparam int FLASH_OP_CYCLES = FLASH_OP_TIME_US * CLK_MHZ;
  localparam int SLOT_CYCLES = 4;

  // Bit 0 read start up to bit 6 write error
  typedef struct packed {
    logic write_error_flag;
    logic config_space_select_bit;
    logic latch_load_only_bit;
    logic free;
    logic write_enable_bit;
    logic wr;
    logic rd;
  } fsws_ctrl_type;
  localparam fsws_ctrl_type CTRL_RESET = 7'h00;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'h0,
    KEY_HALF = 2'h1,
    KEY_ARMED = 2'h2
  } fsws_key_type;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_SLOT1 = 2'h1,
    SEQ_SLOT2 = 2'h2,
    SEQ_STALL = 2'h3
  } fsws_seq_type;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_READ = 3'h1,
    OP_LOAD = 3'h2,
    OP_ERASE = 3'h3,
    OP_PROG = 3'h4
  } fsws_op_type;

  typedef struct packed {
    logic busy;
    logic stall;
    logic nop;
    fsws_key_type key;
  } fsws_status_type;
endpackage : fsws_pkg

// *** logic/fsws_cycle_timer.sv ***
/*
 One-shot cycle timer: done pulses CYCLES edges after start.
 Assumes start and abort come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module fsws_cycle_timer #(
  parameter int CYCLES = fsws_pkg::FLASH_OP_CYCLES
) (
  input wire logic mclk,  // Core clock
  input wire logic rst_n, // Async reset
  input wire logic start, // Arm pulse
  input wire logic abort, // Cancel run
  output logic done       // Expiry pulse
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic running;
  logic next_running;
  logic next_done;

  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'b0;
    if (abort) begin
      next_running = 1'b0;
      next_count = '0;
    end else if (start) begin
      next_running = 1'b1;
      next_count = CW'(CYCLES);
    end else if (running) begin
      next_count = count - 1'b1;
      if (count == CW'(1)) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      running <= next_running;
      done <= next_done;
    end
  end
endmodule : fsws_cycle_timer
`default_nettype wire

// *** logic/fsws_latch_bank.sv ***
/*
 Row write latches, blank after reset and after each clear.
 Assumes load and clear never coincide; clear wins if they do.
*/
`timescale 1ns/1ns
`default_nettype none
module fsws_latch_bank #(
  parameter int COUNT = fsws_pkg::LATCH_COUNT,
  parameter int WIDTH = fsws_pkg::WORD_W,
  parameter int IDX_W = fsws_pkg::LATCH_IDX_W
) (
  input wire logic mclk,                    // Core clock
  input wire logic rst_n,                   // Async reset
  input wire logic clear,                   // Back to blank
  input wire logic load,                    // Write one latch
  input wire logic [IDX_W-1:0] idx,         // Latch select
  input wire logic [WIDTH-1:0] din,         // Latch data
  output logic [COUNT*WIDTH-1:0] latchVec   // All latches
);
  logic [WIDTH-1:0] latch [COUNT];
  logic [WIDTH-1:0] next_latch [COUNT];

  always_comb begin
    for (int i = 0; i < COUNT; i++) begin
      next_latch[i] = latch[i];
      if (clear) begin
        next_latch[i] = fsws_pkg::BLANK_WORD;
      end else if (load && idx == IDX_W'(i)) begin
        next_latch[i] = din;
      end
      latchVec[i*WIDTH +: WIDTH] = latch[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < COUNT; i++) begin
        latch[i] <= fsws_pkg::BLANK_WORD;
      end
    end else begin
      for (int i = 0; i < COUNT; i++) begin
        latch[i] <= next_latch[i];
      end
    end
  end
endmodule : fsws_latch_bank
`default_nettype wire

// *** logic/fsws_sequencer.sv ***
/*
 Flash self-write sequencer: unlock key, start bits, forced idle slots,
 processor stall, write latches and the program flash array itself.
 Assumes a Wishbone classic master on mclk and a core that obeys
 nopForce and cpuStall at each instrSlot pulse.
*/
// Chosen here: the placing of the registers and the Wishbone register port.
// Overview of operation
// - Key 55 then AA must precede write start, in that order.
// - Erase, latch load, program and user-ID program all need key.
// - Two instruction slots after write start are forced idle.
// - Erase or program stalls the core for about 2 ms.
// - Latch load gets the two idle slots and no stall.
// - Clocks and slot divider keep running during the stall.
// - After a stall the core resumes at the third instruction.
// - A broken key or start sequence loads and programs nothing.
// - Erase select with write enable erases the addressed whole row.
// - Programming never erases; bits only clear.
// - A program writes at most the 16 latches.
// - Upper address picks the row, low bits pick the latch.
// - Loads and programs stay inside the addressed row.
// - Latches return to 3FFF after each write or erase.
// - Load-only set: start just copies data into one latch.
// - Load-only clear: load final latch, program whole row.
// - Start bits are set by software, cleared only by hardware.
// - A run-time reset (sysRst) during a write sets the write error flag; power-on reset clears it.
// - Writes and erases need write enable, cleared at power-up.
// - Read fetch uses the second slot; data ready afterwards.
`timescale 1ns/1ns
`default_nettype none
module fsws_sequencer #(
  parameter int OP_CYCLES = fsws_pkg::FLASH_OP_CYCLES,
  parameter int SLOT_CYCLES = fsws_pkg::SLOT_CYCLES,
  parameter int ARRAY_WORDS = fsws_pkg::ARRAY_WORDS,
  parameter logic [13:0] DEVICE_ID = 14'h0123 // Arbitrary value
) (
  input wire logic mclk,            // Core clock, 125 MHz
  input wire logic rst_n,           // Power-on reset, async
  input wire logic sysRst,          // Run-time reset, sync
  input wire logic wb_cyc_i,        // Bus cycle
  input wire logic wb_stb_i,        // Bus strobe
  input wire logic wb_we_i,         // Bus write
  input wire logic [7:0] wb_adr_i,  // Byte address
  input wire logic [3:0] wb_sel_i,  // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o,     // Read data
  output logic wb_ack_o,            // Bus acknowledge
  output logic instrSlot,           // Instruction slot pulse
  output logic nopForce,            // Current slot is idle
  output logic cpuStall             // Core held
);
  localparam int AW = $clog2(ARRAY_WORDS);
  localparam int SW = $clog2(SLOT_CYCLES + 1);
  localparam int LC = fsws_pkg::LATCH_COUNT;
  localparam int LW = fsws_pkg::LATCH_IDX_W;
  localparam int WW = fsws_pkg::WORD_W;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  fsws_pkg::fsws_ctrl_type ctrl, next_ctrl, wc;
  fsws_pkg::fsws_key_type keyState, next_keyState;
  fsws_pkg::fsws_seq_type seq, next_seq;
  fsws_pkg::fsws_op_type op, next_op;
  fsws_pkg::fsws_status_type status;
  logic [7:0] addrLo, next_addrLo, addrHi, next_addrHi;
  logic [7:0] dataLo, next_dataLo, dataHi, next_dataHi;
  logic [31:0] next_datO, rdMux;
  logic [SW-1:0] slotCnt, next_slotCnt;
  logic next_ack, next_slot, next_nop, next_stall;
  logic req, take, wrAcc, startWr, startRd, opDone;
  logic timerStart, timerDone, fetch, loadLatch, commit;
  logic [7:0] wdat;
  logic [14:0] addrFull;
  logic [AW-1:0] wordIdx;
  logic [WW-1:0] rdWord;
  logic [LC*WW-1:0] latchVec;
  logic [WW-1:0] flash [ARRAY_WORDS];
  logic [WW-1:0] userId [fsws_pkg::USER_ID_WORDS];

  assign req = wb_cyc_i & wb_stb_i;
  assign take = req & wb_ack_o;
  assign wrAcc = take & wb_we_i & wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];
  assign wc = wdat[6:0];
  assign addrFull = {addrHi[6:0], addrLo};
  assign wordIdx = addrFull[AW-1:0];
  assign status = {seq != fsws_pkg::SEQ_IDLE, cpuStall, nopForce, keyState};

  // Only a fresh armed key with enable set may start a write
  assign startWr = wrAcc && hit(wb_adr_i, fsws_pkg::OFS_CTRL) && wc.wr && wc.write_enable_bit
                   && keyState == fsws_pkg::KEY_ARMED && seq == fsws_pkg::SEQ_IDLE
                   && !sysRst;
  assign startRd = wrAcc && hit(wb_adr_i, fsws_pkg::OFS_CTRL) && wc.rd && !wc.wr
                   && seq == fsws_pkg::SEQ_IDLE && !sysRst;

  always_comb begin
    next_keyState = keyState;
    if (wrAcc && hit(wb_adr_i, fsws_pkg::OFS_KEY)) begin
      if (keyState == fsws_pkg::KEY_IDLE && wdat == fsws_pkg::KEY_FIRST) begin
        next_keyState = fsws_pkg::KEY_HALF;
      end else if (keyState == fsws_pkg::KEY_HALF && wdat == fsws_pkg::KEY_SECOND) begin
        next_keyState = fsws_pkg::KEY_ARMED;
      end else begin
        next_keyState = fsws_pkg::KEY_IDLE;
      end
    end else if (wrAcc) begin
      // Any other write, the start itself included, spends the key
      next_keyState = fsws_pkg::KEY_IDLE;
    end
    if (sysRst) begin
      next_keyState = fsws_pkg::KEY_IDLE;
    end
  end

  // Free-running slot divider, never gated by the stall
  always_comb begin
    next_slotCnt = slotCnt + 1'b1;
    next_slot = 1'b0;
    if (slotCnt == SW'(SLOT_CYCLES - 1)) begin
      next_slotCnt = '0;
      next_slot = 1'b1;
    end
  end

  always_comb begin
    next_seq = seq;
    next_op = op;
    next_nop = nopForce;
    next_stall = cpuStall;
    timerStart = 1'b0;
    fetch = 1'b0;
    loadLatch = 1'b0;
    commit = 1'b0;
    opDone = 1'b0;
    case (seq)
      fsws_pkg::SEQ_IDLE: begin
        if (startWr) begin
          next_seq = fsws_pkg::SEQ_SLOT1;
          next_nop = 1'b1;
          if (wc.latch_load_only_bit) begin
            next_op = fsws_pkg::OP_LOAD;
            loadLatch = 1'b1;
          end else if (wc.free) begin
            next_op = fsws_pkg::OP_ERASE;
          end else begin
            next_op = fsws_pkg::OP_PROG;
            loadLatch = 1'b1;
          end
        end else if (startRd) begin
          next_seq = fsws_pkg::SEQ_SLOT1;
          next_op = fsws_pkg::OP_READ;
        end
      end
      fsws_pkg::SEQ_SLOT1: begin
        if (instrSlot) begin
          next_seq = fsws_pkg::SEQ_SLOT2;
          next_nop = 1'b1;
        end
      end
      fsws_pkg::SEQ_SLOT2: begin
        if (instrSlot) begin
          next_nop = 1'b0;
          if (op == fsws_pkg::OP_ERASE || op == fsws_pkg::OP_PROG) begin
            next_seq = fsws_pkg::SEQ_STALL;
            next_stall = 1'b1;
            timerStart = 1'b1;
          end else begin
            // Load-only finishes here with no stall
            next_seq = fsws_pkg::SEQ_IDLE;
            fetch = (op == fsws_pkg::OP_READ);
            opDone = 1'b1;
            next_op = fsws_pkg::OP_NONE;
          end
        end
      end
      fsws_pkg::SEQ_STALL: begin
        if (timerDone) begin
          commit = 1'b1;
          opDone = 1'b1;
          next_stall = 1'b0;
          next_seq = fsws_pkg::SEQ_IDLE;
          next_op = fsws_pkg::OP_NONE;
        end
      end
      default: begin
        next_seq = fsws_pkg::SEQ_IDLE;
      end
    endcase
    if (sysRst) begin
      next_seq = fsws_pkg::SEQ_IDLE;
      next_op = fsws_pkg::OP_NONE;
      next_nop = 1'b0;
      next_stall = 1'b0;
      commit = 1'b0;
      loadLatch = 1'b0;
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    if (wrAcc && hit(wb_adr_i, fsws_pkg::OFS_CTRL) && seq == fsws_pkg::SEQ_IDLE) begin
      next_ctrl.write_enable_bit = wc.write_enable_bit;
      next_ctrl.free = wc.free;
      next_ctrl.latch_load_only_bit = wc.latch_load_only_bit;
      next_ctrl.config_space_select_bit = wc.config_space_select_bit;
      next_ctrl.write_error_flag = ctrl.write_error_flag & wc.write_error_flag;
    end
    if (opDone) begin
      next_ctrl.rd = 1'b0;
      next_ctrl.wr = 1'b0;
    end
    // Software can only set the start bits
    if (startWr) begin
      next_ctrl.wr = 1'b1;
    end
    if (startRd) begin
      next_ctrl.rd = 1'b1;
    end
    if (sysRst) begin
      next_ctrl = fsws_pkg::CTRL_RESET;
      next_ctrl.write_error_flag = ctrl.write_error_flag | ctrl.wr;
    end
  end

  always_comb begin
    rdWord = '0;
    if (!ctrl.config_space_select_bit) begin
      rdWord = flash[wordIdx];
    end else if (addrFull[14:2] == 13'h0000) begin
      rdWord = userId[addrFull[1:0]];
    end else if (addrFull == fsws_pkg::CFG_DEVID_ADDR) begin
      rdWord = DEVICE_ID;
    end
  end

  always_comb begin
    next_addrLo = addrLo;
    next_addrHi = addrHi;
    next_dataLo = dataLo;
    next_dataHi = dataHi;
    if (wrAcc && hit(wb_adr_i, fsws_pkg::OFS_ADDR_LO)) begin
      next_addrLo = wdat;
    end
    if (wrAcc && hit(wb_adr_i, fsws_pkg::OFS_ADDR_HI)) begin
      next_addrHi = {1'b0, wdat[6:0]};
    end
    if (wrAcc && hit(wb_adr_i, fsws_pkg::OFS_DATA_LO)) begin
      next_dataLo = wdat;
    end
    if (wrAcc && hit(wb_adr_i, fsws_pkg::OFS_DATA_HI)) begin
      next_dataHi = {2'h0, wdat[5:0]};
    end
    if (fetch) begin
      next_dataLo = rdWord[7:0];
      next_dataHi = {2'h0, rdWord[13:8]};
    end
  end

  always_comb begin
    case (wb_adr_i)
      fsws_pkg::OFS_CTRL: rdMux = {25'h0, ctrl};
      fsws_pkg::OFS_ADDR_LO: rdMux = {24'h0, addrLo};
      fsws_pkg::OFS_ADDR_HI: rdMux = {24'h0, addrHi};
      fsws_pkg::OFS_DATA_LO: rdMux = {24'h0, dataLo};
      fsws_pkg::OFS_DATA_HI: rdMux = {24'h0, dataHi};
      fsws_pkg::OFS_STATUS: rdMux = {27'h0, status};
      default: rdMux = 32'h0;
    endcase
    next_ack = req & ~wb_ack_o;
    next_datO = next_ack ? rdMux : 32'h0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= fsws_pkg::CTRL_RESET;
      keyState <= fsws_pkg::KEY_IDLE;
      seq <= fsws_pkg::SEQ_IDLE;
      op <= fsws_pkg::OP_NONE;
      addrLo <= 8'h00;
      addrHi <= 8'h00;
      dataLo <= 8'h00;
      dataHi <= 8'h00;
      slotCnt <= '0;
      instrSlot <= 1'b0;
      nopForce <= 1'b0;
      cpuStall <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      keyState <= next_keyState;
      seq <= next_seq;
      op <= next_op;
      addrLo <= next_addrLo;
      addrHi <= next_addrHi;
      dataLo <= next_dataLo;
      dataHi <= next_dataHi;
      slotCnt <= next_slotCnt;
      instrSlot <= next_slot;
      nopForce <= next_nop;
      cpuStall <= next_stall;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_datO;
    end
  end

  // Array content is not reset, like a real flash
  always_ff @(posedge mclk) begin
    if (commit && !ctrl.config_space_select_bit) begin
      for (int i = 0; i < LC; i++) begin
        if (op == fsws_pkg::OP_ERASE) begin
          flash[{wordIdx[AW-1:LW], LW'(i)}] <= fsws_pkg::BLANK_WORD;
        end else begin
          flash[{wordIdx[AW-1:LW], LW'(i)}] <=
            flash[{wordIdx[AW-1:LW], LW'(i)}] & latchVec[i*WW +: WW];
        end
      end
    end
    if (commit && ctrl.config_space_select_bit && op == fsws_pkg::OP_PROG && addrFull[14:LW] == 11'h000) begin
      for (int i = 0; i < fsws_pkg::USER_ID_WORDS; i++) begin
        userId[i] <= userId[i] & latchVec[i*WW +: WW];
      end
    end
  end

  fsws_latch_bank #(.COUNT(LC), .WIDTH(WW), .IDX_W(LW)) latches (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(commit),
    .load(loadLatch),
    .idx(addrLo[LW-1:0]),
    .din({dataHi[5:0], dataLo}),
    .latchVec(latchVec)
  );

  fsws_cycle_timer #(.CYCLES(OP_CYCLES)) opTimer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(timerStart),
    .abort(sysRst),
    .done(timerDone)
  );

  int stallCnt;
  localparam int STALL_LEN = OP_CYCLES + 1;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stallCnt <= 0;
    end else begin
      stallCnt <= cpuStall ? stallCnt + 1 : 0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || sysRst);

  chk_key_order: assert property ($rose(ctrl.wr)
    |-> $past(keyState) == fsws_pkg::KEY_ARMED)
    else $error("write started without full key");
  chk_nop_pair: assert property ($rose(ctrl.wr) |-> nopForce [*2])
    else $error("idle slots not forced");
  // Counter already holds the full length when the stall drops; aborts are excluded
  chk_stall_len: assert property ($fell(cpuStall) && !$past(sysRst)
    |-> stallCnt == STALL_LEN)
    else $error("stall length wrong");
  chk_load_nostall: assert property (op == fsws_pkg::OP_LOAD |-> !cpuStall)
    else $error("latch load stalled the core");
  chk_resume_slot: assert property ($fell(cpuStall) |-> !nopForce && !ctrl.wr)
    else $error("resume not clean");
  chk_load_only: assert property (startWr && wc.latch_load_only_bit |=> op == fsws_pkg::OP_LOAD)
    else $error("load-only start programmed");
  chk_latch_blank: assert property (commit |=> latchVec == {LC{fsws_pkg::BLANK_WORD}})
    else $error("latches not blank after op");
  chk_wr_clear: assert property ($fell(ctrl.wr) |-> $past(opDone) || $past(sysRst))
    else $error("write start cleared early");
  chk_write_enable_bit_gate: assert property ($rose(ctrl.wr) |-> ctrl.write_enable_bit)
    else $error("write without enable");
  chk_read_fetch: assert property ($rose(ctrl.rd) |-> ##[1:40] $fell(ctrl.rd))
    else $error("read never completed");
  chk_key_break: assert property (wrAcc && hit(wb_adr_i, fsws_pkg::OFS_KEY)
    && keyState == fsws_pkg::KEY_HALF && wdat != fsws_pkg::KEY_SECOND
    |=> keyState == fsws_pkg::KEY_IDLE)
    else $error("bad key kept state");
  chk_err_flag: assert property (disable iff (!rst_n) sysRst && ctrl.wr |=> ctrl.write_error_flag)
    else $error("write error not flagged");

  cov_erase: cover property (commit && op == fsws_pkg::OP_ERASE);
  cov_prog: cover property (commit && op == fsws_pkg::OP_PROG);
  cov_load: cover property (loadLatch && wc.latch_load_only_bit);
  cov_read: cover property (fetch);
endmodule : fsws_sequencer
`default_nettype wire

// *** verif/tb_top.sv ***
/*
 Self-checking bench for the flash self-write sequencer over Wishbone.
 Assumes the design's own assertions; the flash op time is shortened.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int OPC = 20;
  logic mclk, rst_n, sysRst, cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datI, datO, q;
  logic ack, instrSlot, nopForce, cpuStall;
  int failures, compares, nopCnt, stallCnt, slotPulses;

  fsws_sequencer #(.OP_CYCLES(OPC)) fsws_sequencer_inst (
    .mclk(mclk), .rst_n(rst_n), .sysRst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .instrSlot(instrSlot), .nopForce(nopForce), .cpuStall(cpuStall)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic summarize();
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; ends one idle cycle after the ack edge
  task automatic wbAcc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= {24'h0, d};
    sel <= 4'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) chk(32'h0, 32'h1);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask : wbAcc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wbAcc(1'b1, a, d);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    wbAcc(1'b0, a, 8'h00);
    chk(q, exp);
  endtask : rdChk

  // Key, start, then count forced idle and stall cycles
  task automatic startOp(input logic [7:0] ctrl);
    wr(fsws_pkg::OFS_KEY, fsws_pkg::KEY_FIRST);
    wr(fsws_pkg::OFS_KEY, fsws_pkg::KEY_SECOND);
    wr(fsws_pkg::OFS_CTRL, ctrl | 8'h02);
    nopCnt = 0;
    stallCnt = 0;
    slotPulses = 0;
    repeat (OPC + 40) begin
      if (nopForce === 1'b1) nopCnt++;
      if (cpuStall === 1'b1) stallCnt++;
      if (instrSlot === 1'b1) slotPulses++;
      @(posedge mclk);
    end
  endtask : startOp

  task automatic readWord(input logic [7:0] a, input logic [13:0] exp);
    logic [7:0] lo;
    int n;
    wr(fsws_pkg::OFS_ADDR_LO, a);
    wr(fsws_pkg::OFS_ADDR_HI, 8'h00);
    wr(fsws_pkg::OFS_CTRL, 8'h01);
    n = 0;
    do begin
      wbAcc(1'b0, fsws_pkg::OFS_CTRL, 8'h00);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    chk(32'(q[0]), 32'h0);
    wbAcc(1'b0, fsws_pkg::OFS_DATA_LO, 8'h00);
    lo = q[7:0];
    wbAcc(1'b0, fsws_pkg::OFS_DATA_HI, 8'h00);
    chk({18'h0, q[5:0], lo}, {18'h0, exp});
  endtask : readWord

  task automatic loadData(input logic [7:0] a, input logic [13:0] d);
    wr(fsws_pkg::OFS_ADDR_LO, a);
    wr(fsws_pkg::OFS_ADDR_HI, 8'h00);
    wr(fsws_pkg::OFS_DATA_LO, d[7:0]);
    wr(fsws_pkg::OFS_DATA_HI, {2'h0, d[13:8]});
  endtask : loadData

  // Mode bits stay as written; only the start bit is cleared by hardware
  task automatic chkNop(input int expStall, input logic [7:0] expCtrl);
    chk(32'(nopCnt >= 5 && nopCnt <= 8), 32'h1);
    chk(32'(stallCnt), 32'(expStall));
    chk(32'(slotPulses), 32'((OPC + 40) / fsws_pkg::SLOT_CYCLES));
    rdChk(fsws_pkg::OFS_CTRL, {24'h0, expCtrl});
  endtask : chkNop

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    summarize();
  end

  initial begin
    failures = 0;
    compares = 0;
    rst_n = 1'b0;
    sysRst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    datI = 32'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdChk(fsws_pkg::OFS_CTRL, 32'h0);
    rdChk(fsws_pkg::OFS_STATUS, 32'h0);
    rdChk(fsws_pkg::OFS_KEY, 32'h0);
    rdChk(8'h40, 32'h0);
    // Start with no key at all
    wr(fsws_pkg::OFS_CTRL, 8'h06);
    rdChk(fsws_pkg::OFS_CTRL, 32'h04);
    wr(fsws_pkg::OFS_KEY, 8'h55);
    rdChk(fsws_pkg::OFS_STATUS, 32'h01);
    wr(fsws_pkg::OFS_KEY, 8'h11);
    rdChk(fsws_pkg::OFS_STATUS, 32'h00);
    wr(fsws_pkg::OFS_KEY, 8'h55);
    wr(fsws_pkg::OFS_KEY, 8'haa);
    rdChk(fsws_pkg::OFS_STATUS, 32'h02);
    // Any other write between key and start breaks the sequence
    wr(fsws_pkg::OFS_ADDR_LO, 8'h27);
    wr(fsws_pkg::OFS_CTRL, 8'h06);
    rdChk(fsws_pkg::OFS_CTRL, 32'h04);
    startOp(8'h00);
    chk(32'(nopCnt + stallCnt), 32'h0);
    // Erase row at 0x20 through an address inside it
    startOp(8'h0c);
    chkNop(OPC + 1, 8'h0c);
    loadData(8'h22, 14'h1234);
    startOp(8'h14);
    chkNop(0, 8'h14);
    readWord(8'h22, 14'h3fff);
    loadData(8'h23, 14'h0abc);
    startOp(8'h04);
    chkNop(OPC + 1, 8'h04);
    readWord(8'h22, 14'h1234);
    readWord(8'h23, 14'h0abc);
    readWord(8'h2f, 14'h3fff);
    // Latches blank again, and programming only clears bits
    loadData(8'h23, 14'h3f0f);
    startOp(8'h04);
    readWord(8'h23, 14'h0a0c);
    readWord(8'h22, 14'h1234);
    // Run-time reset in the middle of an erase stall
    wr(fsws_pkg::OFS_KEY, 8'h55);
    wr(fsws_pkg::OFS_KEY, 8'haa);
    wr(fsws_pkg::OFS_CTRL, 8'h0e);
    repeat (12) @(posedge mclk);
    chk(32'(cpuStall), 32'h1);
    sysRst <= 1'b1;
    @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    rdChk(fsws_pkg::OFS_CTRL, 32'h40);
    wr(fsws_pkg::OFS_CTRL, 8'h00);
    rdChk(fsws_pkg::OFS_CTRL, 32'h00);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
